// file: shared/gpio_port_pkg.sv
// Package for the shared-pin parallel port: register map, field layout, widths.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
package gpio_port_pkg;

   // ==========================================================
   // Widths
   localparam int unsigned PIN_COUNT    = 16;
   localparam int unsigned SEL_W        = 5;
   localparam int unsigned IN_REMAP_N   = 14;
   localparam int unsigned OUT_REMAP_N  = 13;
   localparam int unsigned REMAP_N      = IN_REMAP_N + OUT_REMAP_N;
   localparam int unsigned FUNC_N       = 4;

   // ==========================================================
   // Register byte offsets
   localparam logic [11:0] DIR_OFS      = 12'h000;
   localparam logic [11:0] LATCH_OFS    = 12'h004;
   localparam logic [11:0] LEVEL_OFS    = 12'h008;
   localparam logic [11:0] ANCFG_OFS    = 12'h00c;
   localparam logic [11:0] LOCK_OFS     = 12'h010;
   localparam logic [11:0] REMAP_BASE   = 12'h100;
   localparam logic [11:0] REMAP_LAST   = 12'h168;
   localparam int unsigned OUT_REMAP_12 = IN_REMAP_N + 12;

   // ==========================================================
   // Fields and reset values
   localparam int unsigned LOCK_BIT     = 6;
   localparam int unsigned HI_SEL_LSB   = 8;
   localparam logic [15:0] REMAP_MASK   = 16'h1f1f;
   localparam logic [15:0] DIR_RESET    = 16'hffff;
   localparam logic [15:0] LATCH_RESET  = 16'h0000;
   localparam logic [15:0] ANCFG_RESET  = 16'h0000;
   localparam logic [15:0] REMAP_RESET  = 16'h0000;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0]  HSIZE_WORD   = 3'h2;

   // Pin variant masks; implemented pins, analog-capable pins and input-only pins
   localparam logic [15:0] PIN_IMPL     = 16'hffff;
   localparam logic [15:0] PIN_ANALOG   = 16'h000f;
   localparam logic [15:0] PIN_IN_ONLY  = 16'h0000;

   // Peripheral request for one pin, function 0 has highest priority
   typedef struct packed {
      logic [FUNC_N-1:0] enable;
      logic [FUNC_N-1:0] drive;
      logic [FUNC_N-1:0] out;
   } periph_req_s;

   // Pin driver for one pin
   typedef struct packed {
      logic out;
      logic oe;
   } pin_drv_s;

endpackage

// file: rtl/pin_mux.sv
// One pin's output ownership and input gating.
// Assumes pin input already synchronised in the hclk domain.
`timescale 1ns/1ps
`default_nettype none
module pin_mux (
   // Port side
   input  wire logic                       dir_in,
   input  wire logic                       latch_bit,
   input  wire logic                       analog_mode,
   input  wire logic                       in_only,
   // Peripheral side
   input  wire gpio_port_pkg::periph_req_s req,
   output logic                            periph_in,
   // Pad side
   input  wire logic                       pin_sync,
   output gpio_port_pkg::pin_drv_s         drv,
   output logic                            level
);
   logic owned;
   logic owner_out;

   // ==========================================================
   // Priority: lowest-numbered enabled function wins
   always_comb begin
      owned     = 1'b0;
      owner_out = 1'b0;
      if (!in_only) begin // [RULE9]
         for (int i = gpio_port_pkg::FUNC_N - 1; i >= 0; i--) begin
            if (req.enable[i]) begin // [RULE14]
               owned     = req.drive[i]; // [RULE1] [RULE2]
               owner_out = req.out[i];
            end
         end
      end
   end

   always_comb begin
      if (owned) begin
         drv.out = owner_out; // [RULE1]
         drv.oe  = 1'b1;
      end else begin
         drv.out = latch_bit; // [RULE2] [RULE4]
         drv.oe  = !dir_in; // [RULE13]
      end
   end

   // Analog disables digital input buffer
   assign level = analog_mode ? 1'b0 : pin_sync; // [RULE11]
   // Port-driven value never feeds peripheral: only foreign drive reaches it
   assign periph_in = (!owned && drv.oe) ? 1'b0 : level; // [RULE3]

endmodule // pin_mux
`default_nettype wire

// file: rtl/gpio_port.sv
// Shared-pin parallel port with AHB-Lite register access and pin remap selects.
// Assumes one hclk domain; pins are asynchronous and synchronised here.
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: Active enabled peripheral owns pin output
// RULE2: Idle enabled peripheral leaves port driving
// RULE3: Port output never loops to peripheral
// RULE4: Direction one is input, zero output
// RULE5: Reset makes every pin input
// RULE6: Latch register reads and writes latch
// RULE7: Level reads pins, writes hit latch
// RULE8: Unimplemented pin bits read zero
// RULE9: Input-only shared pin is dedicated port
// RULE10: Analog-shared pins reset as analog
// RULE11: Analog pin digital read returns zero
// RULE12: Software sets config bit for digital
// RULE13: Output driver usable while analog
// RULE14: Highest priority enabled function wins
// RULE15: Twenty-seven remap registers, 14 in, 13 out
// RULE16: Remap writes only while unlocked
// RULE17: Pin 25 and 24 select fields
// RULE18: Remap unused bits read zero
// RULE19: Pin levels sampled on clock
module gpio_port (
   // Clock and reset
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   // AHB-Lite slave
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic                        hready,
   input  wire logic [31:0]                 hwdata,
   output logic [31:0]                      hrdata,
   output logic                             hreadyout,
   output logic                             hresp,
   // Peripherals
   input  wire gpio_port_pkg::periph_req_s  periph_req [gpio_port_pkg::PIN_COUNT],
   output logic [15:0]                      periph_in,
   output logic [4:0]                       pin24_output_select,
   output logic [4:0]                       pin25_output_select,
   // Pads
   input  wire logic [15:0]                 pin_in,
   output logic [15:0]                      pin_out,
   output logic [15:0]                      pin_oe
);
   logic [15:0] pin_direction_reg;
   logic [15:0] output_latch_reg;
   logic [15:0] pin_level_reg;
   logic [15:0] analog_pin_config_low;
   logic        remap_lock_bit;
   logic [15:0] remap_reg [gpio_port_pkg::REMAP_N];
   logic [15:0] sync1_reg;
   logic [15:0] sync2_reg;
   logic [15:0] level_now;
   logic [15:0] analog_mode;
   gpio_port_pkg::pin_drv_s drv [gpio_port_pkg::PIN_COUNT];

   // Data phase capture
   logic        wr_pend_reg;
   logic        rd_pend_reg;
   logic [11:0] addr_reg;
   logic        take;
   logic        remap_hit;
   logic [4:0]  remap_idx;
   logic [11:0] remap_ofs;

   // ==========================================================
   // Pin synchroniser and level sampling
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= 16'h0000;
         sync2_reg <= 16'h0000;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_level_reg <= 16'h0000;
      end else begin
         pin_level_reg <= level_now & gpio_port_pkg::PIN_IMPL; // [RULE19] [RULE8]
      end
   end

   // Analog when capable and config bit still zero
   assign analog_mode = gpio_port_pkg::PIN_ANALOG & ~analog_pin_config_low; // [RULE10]

   // ==========================================================
   // Per-pin muxes
   genvar g;
   generate
      for (g = 0; g < gpio_port_pkg::PIN_COUNT; g++) begin : g_pin
         pin_mux u_mux (
            .dir_in      (pin_direction_reg[g]),
            .latch_bit   (output_latch_reg[g]),
            .analog_mode (analog_mode[g]),
            .in_only     (gpio_port_pkg::PIN_IN_ONLY[g]),
            .req         (periph_req[g]),
            .periph_in   (periph_in[g]),
            .pin_sync    (sync2_reg[g]),
            .drv         (drv[g]),
            .level       (level_now[g])
         );
         assign pin_out[g] = drv[g].out & gpio_port_pkg::PIN_IMPL[g];
         assign pin_oe[g]  = drv[g].oe & gpio_port_pkg::PIN_IMPL[g]; // [RULE8]
      end
   endgenerate

   // ==========================================================
   // AHB-Lite address phase
   assign take = hsel && hready && (htrans == gpio_port_pkg::HTRANS_NONSEQ);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 12'h000;
      end else begin
         wr_pend_reg <= take && hwrite;
         rd_pend_reg <= take && !hwrite;
         if (take) begin
            addr_reg <= haddr[11:0];
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   assign remap_ofs = addr_reg - gpio_port_pkg::REMAP_BASE;
   assign remap_idx = remap_ofs[6:2];
   assign remap_hit = (addr_reg >= gpio_port_pkg::REMAP_BASE)
                      && (addr_reg <= gpio_port_pkg::REMAP_LAST)
                      && (addr_reg[1:0] == 2'h0); // [RULE15]

   // ==========================================================
   // Port registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_direction_reg <= gpio_port_pkg::DIR_RESET; // [RULE5]
      end else if (wr_pend_reg && addr_reg == gpio_port_pkg::DIR_OFS) begin
         pin_direction_reg <= hwdata[15:0] | ~gpio_port_pkg::PIN_IMPL; // [RULE4]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         output_latch_reg <= gpio_port_pkg::LATCH_RESET;
      end else if (wr_pend_reg && (addr_reg == gpio_port_pkg::LATCH_OFS
                                   || addr_reg == gpio_port_pkg::LEVEL_OFS)) begin
         output_latch_reg <= hwdata[15:0] & gpio_port_pkg::PIN_IMPL; // [RULE6] [RULE7]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         analog_pin_config_low <= gpio_port_pkg::ANCFG_RESET; // [RULE10]
      end else if (wr_pend_reg && addr_reg == gpio_port_pkg::ANCFG_OFS) begin
         analog_pin_config_low <= hwdata[15:0] & gpio_port_pkg::PIN_ANALOG; // [RULE12]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         remap_lock_bit <= 1'b0;
      end else if (wr_pend_reg && addr_reg == gpio_port_pkg::LOCK_OFS) begin
         remap_lock_bit <= hwdata[gpio_port_pkg::LOCK_BIT];
      end
   end

   // ==========================================================
   // Remap registers behind the lock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < gpio_port_pkg::REMAP_N; i++) begin
            remap_reg[i] <= gpio_port_pkg::REMAP_RESET; // [RULE17]
         end
      end else if (wr_pend_reg && remap_hit && !remap_lock_bit) begin // [RULE16]
         remap_reg[remap_idx] <= hwdata[15:0] & gpio_port_pkg::REMAP_MASK; // [RULE18]
      end
   end

   assign pin24_output_select =
      remap_reg[gpio_port_pkg::OUT_REMAP_12][gpio_port_pkg::SEL_W-1:0]; // [RULE17]
   assign pin25_output_select = // [RULE17]
      remap_reg[gpio_port_pkg::OUT_REMAP_12][gpio_port_pkg::HI_SEL_LSB +: gpio_port_pkg::SEL_W];

   // ==========================================================
   // Read data
   always_comb begin
      hrdata = 32'h0000_0000;
      if (rd_pend_reg) begin
         if (addr_reg == gpio_port_pkg::DIR_OFS) begin
            hrdata[15:0] = pin_direction_reg & gpio_port_pkg::PIN_IMPL; // [RULE8]
         end else if (addr_reg == gpio_port_pkg::LATCH_OFS) begin
            hrdata[15:0] = output_latch_reg; // [RULE6]
         end else if (addr_reg == gpio_port_pkg::LEVEL_OFS) begin
            hrdata[15:0] = pin_level_reg; // [RULE7]
         end else if (addr_reg == gpio_port_pkg::ANCFG_OFS) begin
            hrdata[15:0] = analog_pin_config_low;
         end else if (addr_reg == gpio_port_pkg::LOCK_OFS) begin
            hrdata[gpio_port_pkg::LOCK_BIT] = remap_lock_bit;
         end else if (remap_hit) begin
            hrdata[15:0] = remap_reg[remap_idx]; // [RULE18]
         end
      end
   end

   // ==========================================================
   // Assertions
   a_analog_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
      analog_mode[0] |=> !pin_level_reg[0])
      else $error("analog pin read as one");

   a_level_sampled: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE19]
      (analog_mode == 16'h0000) ##1 (analog_mode == 16'h0000)
      |-> pin_level_reg == $past(sync2_reg))
      else $error("pin level not sampled");

   a_lock_holds: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE16]
      (wr_pend_reg && remap_lock_bit) |=> $stable(pin24_output_select)
                                          && $stable(pin25_output_select))
      else $error("remap changed while locked");

   a_remap_write: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE17]
      (wr_pend_reg && !remap_lock_bit && remap_hit
       && remap_idx == 5'(gpio_port_pkg::OUT_REMAP_12))
      |=> pin24_output_select == $past(hwdata[4:0])
          && pin25_output_select == $past(hwdata[12:8]))
      else $error("remap fields not written");

   a_remap_reserved: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE18]
      (rd_pend_reg && remap_hit) |-> (hrdata[15:13] == 3'h0 && hrdata[7:5] == 3'h0))
      else $error("reserved remap bits set");

   a_latch_write: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE7]
      (wr_pend_reg && addr_reg == gpio_port_pkg::LEVEL_OFS)
      |=> output_latch_reg == $past(hwdata[15:0]))
      else $error("level write missed latch");

   a_port_drives: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE4]
      (periph_req[0].enable == 4'h0 && !pin_direction_reg[0])
      |-> pin_oe[0] && pin_out[0] == output_latch_reg[0])
      else $error("output pin not driven from latch");

   a_periph_owns: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE1]
      (periph_req[5].enable[0] && periph_req[5].drive[0])
      |-> pin_oe[5] && pin_out[5] == periph_req[5].out[0])
      else $error("peripheral lost its pin");

   a_idle_periph: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE2]
      (periph_req[5].enable[0] && !periph_req[5].drive[0] && !pin_direction_reg[5])
      |-> pin_oe[5] && pin_out[5] == output_latch_reg[5])
      else $error("idle peripheral blocked port drive");

   a_loop_blocked: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE3]
      (pin_oe[0] && periph_req[0].enable == 4'h0) |-> !periph_in[0])
      else $error("port output looped to peripheral");

   a_analog_in_off: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
      analog_mode[1] |-> !periph_in[1])
      else $error("analog pin input buffer active");

   a_latch_rw: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE6]
      (wr_pend_reg && addr_reg == gpio_port_pkg::LATCH_OFS)
      |=> output_latch_reg == $past(hwdata[15:0]))
      else $error("latch write lost");

   a_read_level: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE7]
      (rd_pend_reg && addr_reg == gpio_port_pkg::LEVEL_OFS)
      |-> hrdata[15:0] == pin_level_reg)
      else $error("level read not from pins");

   a_remap_reset: assert property (@(posedge hclk) // [RULE17]
      $rose(hresetn)
      |-> pin24_output_select == gpio_port_pkg::REMAP_RESET[gpio_port_pkg::SEL_W-1:0]
          && pin25_output_select == gpio_port_pkg::REMAP_RESET[gpio_port_pkg::SEL_W-1:0])
      else $error("select fields not cleared by reset");

   a_dir_reset: assert property (@(posedge hclk) // [RULE5]
      $rose(hresetn) |-> pin_direction_reg == gpio_port_pkg::DIR_RESET)
      else $error("pins not inputs after reset");

   c_lock_write: cover property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_reg && remap_hit && remap_lock_bit);
   c_periph_own: cover property (@(posedge hclk) disable iff (!hresetn)
      periph_req[5].enable[0] && periph_req[5].drive[0]);
   c_idle_periph: cover property (@(posedge hclk) disable iff (!hresetn)
      periph_req[5].enable[0] && !periph_req[5].drive[0] && periph_req[5].drive[2]);
   c_level_read: cover property (@(posedge hclk) disable iff (!hresetn)
      rd_pend_reg && addr_reg == gpio_port_pkg::LEVEL_OFS);

endmodule // gpio_port
`default_nettype wire

// file: bench/pad_model.sv
// Pad model: resolves each pad from the port drive and an outside source.
// Assumes the bench holds the outside level steady between checks.
`timescale 1ns/1ps
`default_nettype none
module pad_model (
   // Port drive
   input  wire logic [15:0] pin_out,
   input  wire logic [15:0] pin_oe,
   // Outside world
   input  wire logic [15:0] ext_level,
   output logic      [15:0] pad
);
   // ==========================================================
   // Resolution
   always_comb pad = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pad_model
`default_nettype wire

// file: bench/shared_pin_parallel_port_tb.sv
// Self-checking bench for the shared-pin parallel port.
// Assumes the port package and the gpio_port design are compiled first.
`timescale 1ns/1ps
`default_nettype none
module shared_pin_parallel_port_tb;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic        hwrite;
   logic        hreadyout;
   logic        hresp;
   logic        rdy_s;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [31:0] hrd_s;
   logic [31:0] rd;
   logic [31:0] v;
   logic [31:0] seed;
   logic [15:0] periph_in;
   logic [15:0] pin_in;
   logic [15:0] pin_out;
   logic [15:0] pin_oe;
   logic [15:0] ext;
   logic [15:0] lat;
   logic [15:0] dir;
   logic [4:0]  sel24;
   logic [4:0]  sel25;
   int          num_errors;
   int          cmp_count;
   int          cyc;
   gpio_port_pkg::periph_req_s preq [gpio_port_pkg::PIN_COUNT];

   gpio_port uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .periph_req(preq), .periph_in(periph_in), .pin24_output_select(sel24),
      .pin25_output_select(sel25), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

   pad_model u_pad (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pad(pin_in));

   // ==========================================================
   // Clock, sampling and timeout
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      hrd_s <= hrdata;
      rdy_s <= hreadyout;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         num_errors++;
         finish_test();
      end
   end

   // ==========================================================
   // Tasks
   task automatic finish_test();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Single transfer: hold address phase, then data phase, until hready
   task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
      haddr <= a;
      hwrite <= w;
      htrans <= gpio_port_pkg::HTRANS_NONSEQ;
      do begin
         @(posedge hclk);
         #1;
      end while (rdy_s !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge hclk);
         #1;
      end while (rdy_s !== 1'b1);
      rd = hrd_s;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      ahb({20'h0, a}, 1'b1, d);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string m);
      ahb({20'h0, a}, 1'b0, 32'h0);
      chk(rd, exp, m);
   endtask

   // Digital read value: analog pins read zero until set digital
   function automatic logic [31:0] lvl(input logic [15:0] p, input logic [15:0] an);
      return {16'h0, p & (~gpio_port_pkg::PIN_ANALOG | an) & gpio_port_pkg::PIN_IMPL};
   endfunction

   task automatic settle();
      repeat (4) @(posedge hclk);
      #1;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      seed = 32'h9d159825;
      num_errors = 0;
      cmp_count = 0;
      cyc = 0;
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = gpio_port_pkg::HSIZE_WORD;
      hwdata = 32'h0;
      ext = 16'(($random(seed)));
      for (int i = 0; i < 16; i++) preq[i] = '0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      chk(32'(pin_oe), 32'h0, "oe after reset");
      rdc(gpio_port_pkg::DIR_OFS, 32'h0000ffff, "dir reset");
      chk({30'h0, hresp, hreadyout}, 32'h1, "bus response");
      settle();
      rdc(gpio_port_pkg::LEVEL_OFS, lvl(ext, 16'h0), "analog level");
      lat = 16'(($random(seed)));
      wr(gpio_port_pkg::LATCH_OFS, {16'hffff, lat});
      rdc(gpio_port_pkg::LATCH_OFS, {16'h0, lat}, "latch rw");
      lat = 16'(($random(seed)));
      wr(gpio_port_pkg::LEVEL_OFS, {16'h0, lat});
      rdc(gpio_port_pkg::LATCH_OFS, {16'h0, lat}, "level write");
      dir = 16'(($random(seed))) & 16'hffde;
      wr(gpio_port_pkg::DIR_OFS, {16'h0, dir});
      rdc(gpio_port_pkg::DIR_OFS, {16'h0, dir}, "dir rw");
      chk(32'(pin_oe), {16'h0, ~dir}, "oe from dir");
      chk(32'(pin_out & ~dir), 32'(lat & ~dir), "out from latch");
      settle();
      rdc(gpio_port_pkg::LEVEL_OFS, lvl(pin_in, 16'h0), "analog driven");
      wr(gpio_port_pkg::ANCFG_OFS, 32'h0000000f);
      rdc(gpio_port_pkg::LEVEL_OFS, lvl(pin_in, 16'hffff), "digital");
      chk(32'(periph_in), 32'(pin_in & dir), "no loop through");
      // Pin 5: two functions enabled and driving, the first one wins
      preq[5] <= '{enable: 4'h5, drive: 4'h5, out: 4'h4};
      settle();
      chk(32'({pin_oe[5], pin_out[5]}), 32'h2, "priority drive");
      rdc(gpio_port_pkg::LEVEL_OFS, lvl(pin_in, 16'hffff), "periph read");
      // Highest function idle, lower one driving: the port keeps the pin
      preq[5] <= '{enable: 4'h5, drive: 4'h4, out: 4'h4};
      @(posedge hclk);
      #1;
      chk(32'({pin_oe[5], pin_out[5]}), 32'({1'b1, lat[5]}), "idle periph");
      for (int i = 0; i < gpio_port_pkg::REMAP_N; i++) begin
         v = $random(seed);
         wr(gpio_port_pkg::REMAP_BASE + 12'(4 * i), v);
         rdc(gpio_port_pkg::REMAP_BASE + 12'(4 * i), {16'h0, v[15:0] & 16'h1f1f},
            "remap rw");
      end
      chk(32'({sel25, sel24}), 32'({v[12:8], v[4:0]}), "select fields");
      rdc(gpio_port_pkg::REMAP_LAST + 12'h4, 32'h0, "unmapped");
      wr(gpio_port_pkg::LOCK_OFS, 32'h00000040);
      wr(gpio_port_pkg::REMAP_LAST, 32'h0);
      rdc(gpio_port_pkg::REMAP_LAST, {16'h0, v[15:0] & 16'h1f1f}, "locked");
      wr(gpio_port_pkg::LOCK_OFS, 32'h0);
      wr(gpio_port_pkg::REMAP_LAST, 32'hffffffff);
      rdc(gpio_port_pkg::REMAP_LAST, 32'h00001f1f, "unlocked");
      preq[5] <= '0;
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      chk(32'({pin_oe, 11'h0, sel24}), 32'h0, "second reset");
      rdc(gpio_port_pkg::DIR_OFS, 32'h0000ffff, "dir second reset");
      finish_test();
   end
endmodule // shared_pin_parallel_port_tb
`default_nettype wire
